/* File: asr_consts.svh */
// constants for the async serial receiver: register offsets, fields, resets, timing
// assumes inclusion by bare name from design files
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
`define ASR_REG_DATA 4'h0
`define ASR_REG_CTRL 4'h1
`define ASR_REG_STAT 4'h2
`define ASR_REG_INT_EN 4'h3
`define ASR_REG_INT_STAT 4'h4
`define ASR_REG_INT_CLR 4'h5
`define ASR_REG_BAUD 4'h6
`define ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE 0
`define ASR_CTRL_SYNC 1
`define ASR_CTRL_SERIAL_PORT_ENABLE 2
`define ASR_CTRL_NINE 3
`define ASR_CTRL_PERIPHERAL_INTERRUPT_ENABLE 4
`define ASR_CTRL_GLOBAL_INTERRUPT_ENABLE 5
`define ASR_CTRL_RECEIVE_INTERRUPT_ENABLE 6
`define ASR_CTRL_RESET 8'h00
`define ASR_BAUD_RESET 16'h001a
`define ASR_OVS 16
`define ASR_OVS_HALF 8
`define ASR_FIFO_DEPTH 2
`define ASR_EV_CHAR 0
`define ASR_EV_FERR 1
`define ASR_EV_OERR 2
`endif

/* File: asr_pkg.sv */
// types for the async serial receiver
// assumes asr_consts.svh is available
package asr_pkg;
	typedef logic [8:0] asr_char_t;
	typedef enum logic [1:0] {ASR_IDLE, ASR_START, ASR_DATA, ASR_STOP} asr_state_t;
endpackage

/* File: asr_fifo_if.sv */
// link between receiver core and its character fifo
// assumes one clock domain
`timescale 1ns/1ps
interface asr_fifo_if;
	import asr_pkg::*;
	logic push;
	logic pop;
	asr_char_t wdata;
	logic wferr;
	asr_char_t rdata;
	logic rferr;
	logic empty;
	logic full;
	modport src(output push, output pop, output wdata, output wferr,
		input rdata, input rferr, input empty, input full);
	modport fifo(input push, input pop, input wdata, input wferr,
		output rdata, output rferr, output empty, output full);
endinterface

/* File: asr_fifo.sv */
// two-entry character fifo with per-character framing error
// assumes caller never pushes when full nor pops when empty
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_fifo (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic flush,
	// fifo side
	asr_fifo_if.fifo f
);
	import asr_pkg::*;
	asr_char_t mem_r [`ASR_FIFO_DEPTH];
	logic fe_r [`ASR_FIFO_DEPTH];
	logic wp_r, wp_nxt, rp_r, rp_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (flush) begin
			wp_nxt = 1'b0;
			rp_nxt = 1'b0;
			cnt_nxt = 2'h0;
		end else begin
			if (f.push)
				wp_nxt = ~wp_r;
			if (f.pop)
				rp_nxt = ~rp_r;
			cnt_nxt = cnt_r + {1'b0, f.push} - {1'b0, f.pop};
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// storage carries no reset; contents are qualified by the count
	always_ff @(posedge core_clk) begin
		if (f.push && !flush) begin
			mem_r[wp_r] <= f.wdata;
			fe_r[wp_r] <= f.wferr;
		end
	end
	assign f.rdata = mem_r[rp_r];
	assign f.rferr = fe_r[rp_r];
	assign f.empty = (cnt_r == 2'h0);
	assign f.full = (cnt_r == 2'h2);
endmodule

/* File: asr_rx.sv */
// async serial receiver: 16x oversampled recovery, two-character fifo, register port
// assumes a remote transmitter on rx_pin and a plain one-cycle register port
// Functional notes
// [RULE_01] a falling edge on the line starts a character; start bit is low
// [RULE_02] wait half a bit, confirm line still low at start centre
// [RULE_03] high at start centre: abandon silently, hunt for next edge
// [RULE_04] step one bit per data bit, majority vote, shift into shift register
// [RULE_05] stop bit low sets framing error for the character, high clears it
// [RULE_06] after stop bit, push character into fifo and raise pending flag
// [RULE_07] reading data register returns oldest character and removes it
// [RULE_08] after fifo overrun no character is accepted until overrun cleared
// [RULE_09] pending flag high while enabled and fifo holds an unread character
// [RULE_10] pending flag is read-only, set and cleared only by fifo occupancy
// [RULE_11] interrupt needs receive, peripheral and global enables plus pending
// [RULE_12] majority of three samples around each bit centre decides the bit
// [RULE_13] line oversampled at sixteen per bit; shifter advances once per bit
// [RULE_14] fifo holds two characters, a third may be in the shift register
// [RULE_15] characters are eight or nine data bits, moved to fifo together
// [RULE_16] software sets receive enable and port enable, clears clocked mode
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_rx (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// serial line
	input wire logic rx_pin,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// interrupts
	output logic rx_irq,
	output logic evt_irq
);
	import asr_pkg::*;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	asr_fifo_if fq();

	// line synchroniser: first stage feeds only the second
	logic rx_s1_r, rx_s2_r, rx_s3_r;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
		end else begin
			rx_s1_r <= rx_pin;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
		end
	end

	// control registers
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [15:0] baud_r, baud_nxt;
	logic [2:0] ien_r, ien_nxt;
	logic [2:0] ist_r, ist_nxt;
	logic oerr_r, oerr_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic enabled;
	assign enabled = ctrl_r[`ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE] &
		ctrl_r[`ASR_CTRL_SERIAL_PORT_ENABLE] & ~ctrl_r[`ASR_CTRL_SYNC];

	// oversample tick: divider gives sixteen pulses per bit
	logic [15:0] div_r, div_nxt;
	logic tick;
	assign tick = (div_r == 16'h0000);
	always_comb begin
		div_nxt = tick ? baud_r : div_r - 16'h0001; // [RULE_13]
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			div_r <= `ASR_BAUD_RESET;
		else
			div_r <= div_nxt;
	end

	// receiver state machine
	asr_state_t st_r, st_nxt;
	logic [3:0] ph_r, ph_nxt;
	logic [3:0] bit_r, bit_nxt;
	asr_char_t sh_r, sh_nxt;
	logic [2:0] vote_r, vote_nxt;
	logic push, push_fe, maj, vote_bit;
	logic [3:0] nbits;
	assign nbits = ctrl_r[`ASR_CTRL_NINE] ? 4'h9 : 4'h8; // [RULE_15]
	// samples at phases 7,8,9 with the centre at 8
	assign vote_bit = (vote_r[1] & vote_r[0]) | (vote_r[1] & rx_s2_r) |
		(vote_r[0] & rx_s2_r); // [RULE_12]
	assign maj = vote_bit;

	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		vote_nxt = vote_r;
		push = 1'b0;
		push_fe = 1'b0;
		if (tick)
			vote_nxt = {vote_r[0], rx_s2_r};
		if (!enabled) begin
			st_nxt = ASR_IDLE;
		end else begin
			case (st_r)
			ASR_IDLE: begin
				// overrun blocks new characters until cleared
				if (!oerr_r && rx_s3_r && !rx_s2_r) begin // [RULE_01] [RULE_08]
					st_nxt = ASR_START;
					ph_nxt = 4'h0;
					bit_nxt = 4'h0;
				end
			end
			ASR_START: begin
				if (tick) begin
					ph_nxt = ph_r + 4'h1;
					if (ph_r == 4'(`ASR_OVS_HALF + 1)) begin // [RULE_02]
						ph_nxt = 4'h0;
						if (maj)
							st_nxt = ASR_IDLE; // [RULE_03]
						else
							st_nxt = ASR_DATA;
					end
				end
			end
			ASR_DATA: begin
				if (tick) begin
					ph_nxt = ph_r + 4'h1;
					if (ph_r == 4'(`ASR_OVS - 1)) begin // [RULE_04]
						ph_nxt = 4'h0;
						// lsb first; eight-bit characters land in the low byte
						sh_nxt = ctrl_r[`ASR_CTRL_NINE] ? {maj, sh_r[8:1]} :
							{1'b0, maj, sh_r[7:1]};
						bit_nxt = bit_r + 4'h1;
						if (bit_r == nbits - 4'h1)
							st_nxt = ASR_STOP;
					end
				end
			end
			ASR_STOP: begin
				if (tick) begin
					ph_nxt = ph_r + 4'h1;
					if (ph_r == 4'(`ASR_OVS - 1)) begin
						push_fe = ~maj; // [RULE_05]
						push = 1'b1; // [RULE_06]
						st_nxt = ASR_IDLE;
					end
				end
			end
			default: st_nxt = ASR_IDLE;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ASR_IDLE;
			ph_r <= 4'h0;
			bit_r <= 4'h0;
			sh_r <= '0;
			vote_r <= 3'h7;
		end else begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			vote_r <= vote_nxt;
		end
	end

	// fifo hookup: a full fifo turns a finished character into an overrun
	logic rd_data, pop;
	assign rd_data = reg_rd & hit(reg_addr, `ASR_REG_DATA);
	assign pop = rd_data & ~fq.empty; // [RULE_07]
	assign fq.push = push & ~fq.full; // [RULE_14]
	assign fq.pop = pop;
	assign fq.wdata = sh_r;
	assign fq.wferr = push_fe;

	asr_fifo u_fifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.flush(~enabled),
		.f(fq)
	);

	// pending flag follows occupancy gated by enabled; no write path sets or clears it directly
	logic pending;
	assign pending = enabled & ~fq.empty; // [RULE_09] [RULE_10]
	assign rx_irq = pending & ctrl_r[`ASR_CTRL_RECEIVE_INTERRUPT_ENABLE] &
		ctrl_r[`ASR_CTRL_PERIPHERAL_INTERRUPT_ENABLE] &
		ctrl_r[`ASR_CTRL_GLOBAL_INTERRUPT_ENABLE]; // [RULE_11]
	assign evt_irq = |(ist_r & ien_r);

	logic [2:0] ev;
	assign ev = {push & fq.full, push & push_fe & ~fq.full, fq.push};

	// register writes and read data
	always_comb begin
		ctrl_nxt = ctrl_r;
		baud_nxt = baud_r;
		ien_nxt = ien_r;
		ist_nxt = ist_r;
		oerr_nxt = oerr_r;
		rdata_nxt = 16'h0000;
		if (reg_wr) begin
			if (hit(reg_addr, `ASR_REG_CTRL))
				ctrl_nxt = reg_wdata[7:0]; // [RULE_16]
			if (hit(reg_addr, `ASR_REG_BAUD))
				baud_nxt = reg_wdata;
			if (hit(reg_addr, `ASR_REG_INT_EN))
				ien_nxt = reg_wdata[2:0];
			if (hit(reg_addr, `ASR_REG_INT_CLR))
				ist_nxt = ist_r & ~reg_wdata[2:0];
		end
		// clearing receive enable is the only way out of overrun
		if (!ctrl_nxt[`ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE])
			oerr_nxt = 1'b0;
		if (push && fq.full)
			oerr_nxt = 1'b1; // [RULE_08]
		// set wins over a clear in the same cycle
		ist_nxt = ist_nxt | ev;
		if (reg_rd) begin
			case (reg_addr)
			`ASR_REG_DATA:
				rdata_nxt = fq.empty ? 16'h0000 : {fq.rferr, 6'h00, fq.rdata};
			`ASR_REG_CTRL: rdata_nxt = {8'h00, ctrl_r};
			`ASR_REG_STAT:
				rdata_nxt = {11'h000, fq.full, oerr_r, ~fq.empty ? fq.rferr : 1'b0,
					st_r != ASR_IDLE, pending};
			`ASR_REG_INT_EN: rdata_nxt = {13'h0000, ien_r};
			`ASR_REG_INT_STAT: rdata_nxt = {13'h0000, ist_r};
			`ASR_REG_BAUD: rdata_nxt = baud_r;
			default: rdata_nxt = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= `ASR_CTRL_RESET;
			baud_r <= `ASR_BAUD_RESET;
			ien_r <= 3'h0;
			ist_r <= 3'h0;
			oerr_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			ctrl_r <= ctrl_nxt;
			baud_r <= baud_nxt;
			ien_r <= ien_nxt;
			ist_r <= ist_nxt;
			oerr_r <= oerr_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;
endmodule

/* File: asr_rx_asserts.sv */
// checker for asr_rx: register port and interrupt relations
// assumes one-cycle strobes; shadows ctrl and int_en from writes
`timescale 1ns/1ps
module asr_rx_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// line and register port
	input wire logic rx_pin,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// interrupts
	input wire logic rx_irq,
	input wire logic evt_irq
);
	logic [6:0] ctl_r;
	logic [2:0] ien_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// shadows, so gating is judged from the port alone
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_r <= 7'h00;
			ien_r <= 3'h0;
		end else if (reg_wr && reg_addr == 4'h1) begin
			ctl_r <= reg_wdata[6:0];
		end else if (reg_wr && reg_addr == 4'h3) begin
			ien_r <= reg_wdata[2:0];
		end
	end
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside answer cycle");
	a_ctrl_readback: assert property (reg_rd && reg_addr == 4'h1 |=>
		reg_rdata[6:0] == $past(ctl_r)) else $error("ctrl readback wrong");
	a_irq_gated: assert property (rx_irq |-> ctl_r[6] && ctl_r[5] && ctl_r[4])
		else $error("rx irq without all enables");
	a_irq_enabled: assert property (rx_irq |-> ctl_r[0] && !ctl_r[1] && ctl_r[2])
		else $error("pending while receiver disabled");
	a_pend_holds: assert property (rx_irq && !reg_rd &&
		!(reg_wr && reg_addr == 4'h1) |=> rx_irq) else $error("pending dropped without read");
	a_evt_gated: assert property (evt_irq |-> ien_r != 3'h0)
		else $error("event irq with no enable");
	a_pend_stat: assert property (reg_rd && reg_addr == 4'h2 && rx_irq |=> reg_rdata[0])
		else $error("status pending bit low");
	a_data_hi: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[14:9] == 6'h00)
		else $error("data upper bits set");
	c_irq: cover property ($rose(rx_irq));
	c_evt: cover property ($rose(evt_irq));
	c_ferr: cover property (reg_rd && reg_addr == 4'h0 ##1 reg_rdata[15]);
endmodule
bind asr_rx asr_rx_chk chk_u(.core_clk, .nrst, .rx_pin, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .rx_irq, .evt_irq);

/* File: asr_tx_model.sv */
// partner: remote serial transmitter driving the receive line
// assumes bit time in core_clk cycles matches the receiver divider
`timescale 1ns/1ps
module asr_tx_model #(
	parameter int BIT = 32
) (
	// clock
	input wire logic core_clk,
	// serial line, idle high
	output logic line
);
	initial line = 1'b1;
	// lsb first, n data bits, stop level s, then g idle bits for a slow sender
	task send(input logic [8:0] d, input int n, input logic s, input int g);
		@(posedge core_clk);
		line <= 1'b0;
		repeat (BIT) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			line <= d[i];
			repeat (BIT) @(posedge core_clk);
		end
		line <= s;
		repeat (BIT) @(posedge core_clk);
		line <= 1'b1;
		repeat (g * BIT + 4) @(posedge core_clk);
	endtask
	// low pulse that dies well before the start centre
	task glitch;
		@(posedge core_clk);
		line <= 1'b0;
		repeat (4) @(posedge core_clk);
		line <= 1'b1;
		repeat (BIT) @(posedge core_clk);
	endtask
endmodule

/* File: asr_rx_test.sv */
// bench for asr_rx: register driver, queued read checks, serial partner
// assumes baud divider 1, so one bit is 32 clocks
`timescale 1ns/1ps
module asr_rx_test;
	logic core_clk = 0;
	logic nrst = 0;
	logic rx_pin;
	logic [3:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic rd_d = 0;
	logic [15:0] reg_rdata;
	logic rx_irq;
	logic evt_irq;
	logic [31:0] exp_q[$];
	logic [31:0] e;
	logic [7:0] a, b;
	logic [8:0] c;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	asr_rx dut_u(.core_clk, .nrst, .rx_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rx_irq, .evt_irq);
	asr_tx_model tx_u(.core_clk, .line(rx_pin));
	initial forever #10 core_clk = ~core_clk;
	task chk(input string n, input logic [15:0] s, x);
		cmp_count++;
		if (s !== x) begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task test_done;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	// read with mask m and expected x, judged by the watcher
	task rd(input logic [3:0] ad, input logic [15:0] m, x);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_rd <= 1;
		exp_q.push_back({m, x});
		@(posedge core_clk);
		reg_rd <= 0;
	endtask
	// answer stands only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			chk("reg_rdata", reg_rdata & e[31:16], e[15:0]);
		end
		rd_d <= reg_rd;
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		void'($urandom(86318));
		repeat (2) @(posedge core_clk);
		nrst <= 1;
		rd(4'h1, 16'hffff, 16'h0000);
		rd(4'h6, 16'hffff, 16'h001a);
		rd(4'hf, 16'hffff, 16'h0000);
		wr(4'h6, 16'h0001);
		wr(4'h3, 16'h0007);
		wr(4'h1, 16'h0075);
		a = $urandom;
		b = $urandom;
		tx_u.send({1'b0, a}, 8, 1, 0);
		@(negedge core_clk);
		chk("rx_irq", rx_irq, 1);
		chk("evt_irq", evt_irq, 1);
		wr(4'h1, 16'h0035);
		@(negedge core_clk);
		chk("rx_irq", rx_irq, 0);
		wr(4'h2, 16'h0000);
		rd(4'h2, 16'h0001, 16'h0001);
		wr(4'h1, 16'h0075);
		tx_u.send({1'b0, b}, 8, 1, 3);
		rd(4'h0, 16'hffff, {8'h00, a});
		rd(4'h0, 16'hffff, {8'h00, b});
		rd(4'h2, 16'h0001, 16'h0000);
		tx_u.glitch();
		rd(4'h2, 16'h0007, 16'h0000);
		tx_u.send(9'h055, 8, 0, 3);
		rd(4'h4, 16'h0002, 16'h0002);
		rd(4'h0, 16'hffff, 16'h8055);
		wr(4'h3, 16'h0000);
		@(negedge core_clk);
		chk("evt_irq", evt_irq, 0);
		wr(4'h5, 16'h0007);
		wr(4'h3, 16'h0007);
		@(negedge core_clk);
		chk("evt_irq", evt_irq, 0);
		for (int i = 0; i < 4; i++) begin
			tx_u.send(9'h0a0 + i, 8, 1, 2);
		end
		rd(4'h2, 16'h0019, 16'h0019);
		rd(4'h4, 16'h0007, 16'h0005);
		rd(4'h0, 16'hffff, 16'h00a0);
		rd(4'h0, 16'hffff, 16'h00a1);
		rd(4'h0, 16'hffff, 16'h0000);
		wr(4'h1, 16'h0074);
		wr(4'h1, 16'h007d);
		rd(4'h2, 16'h0008, 16'h0000);
		c = $urandom;
		tx_u.send(c, 9, 1, 2);
		rd(4'h0, 16'hffff, {7'h00, c});
		// clocked mode select set: receiver must stay deaf
		wr(4'h1, 16'h007f);
		tx_u.send(9'h1c3, 9, 1, 2);
		rd(4'h2, 16'h0003, 16'h0000);
		@(negedge core_clk);
		chk("rx_irq", rx_irq, 0);
		repeat (3) @(posedge core_clk);
		test_done();
	end
endmodule
